/* hw/tasp_cfg.svh */
`ifndef TASP_CFG_SVH
`define TASP_CFG_SVH

// control byte layout, first bit shifted in is the start bit
`define TASP_CTRL_BITS 8
`define TASP_CTRL_A2 6
`define TASP_CTRL_A1 5
`define TASP_CTRL_A0 4
`define TASP_CTRL_MODE 3
`define TASP_CTRL_SER 2
`define TASP_CTRL_PD1 1
`define TASP_CTRL_PD0 0
// control bits still to arrive when acquisition opens
`define TASP_ACQ_SHIFT 3

// address codes of the four single-ended channels
`define TASP_ADDR_X_POS 3'h1
`define TASP_ADDR_Y_POS 3'h5
`define TASP_ADDR_AUX_ONE 3'h2
`define TASP_ADDR_AUX_TWO 3'h6

// falling-edge counts after the start bit
`define TASP_FALL_ACQ 5'h05
`define TASP_FALL_BUSY 5'h08
`define TASP_FALL_MSB 5'h09
`define TASP_FALL_MAX 5'h1F

// result widths and reset values
`define TASP_RES_BITS 12
`define TASP_RES_BITS_LOW 8
`define TASP_RESULT_RST 12'h000
`define TASP_CTRL_RST 8'h00

`endif

/* hw/tasp_pkg.sv */
package tasp_pkg;
  // channel selected by the address bits of the control byte
  typedef enum logic [2:0] {
    TASP_CH_NONE,
    TASP_CH_X_POS,
    TASP_CH_Y_POS,
    TASP_CH_AUX_ONE,
    TASP_CH_AUX_TWO
  } tasp_chan_t;
endpackage

/* hw/tasp_serial_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tasp_cfg.svh"

// Operation
// RQ1 - result bits shift out on falling edges
// RQ2 - result output floats while select high
// RQ3 - busy output floats while select high
// RQ4 - control bits captured on rising edges
// RQ5 - select low starts and enables shifting
// RQ6 - serial clock also clocks the conversion
// RQ7 - pen touch pulls open-drain line low
// RQ8 - channels numbered X+, Y+, aux one, two
// RQ9 - acquisition starts fifth falling edge, three cycles
// RQ10 - result MSB first, eleven more, then zeros
// RQ11 - result is straight binary code
// RQ12 - host keeps select low whole transaction
module tasp_serial_port #(
  parameter int RES_BITS = `TASP_RES_BITS
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic shift_and_convert_clock,
  input wire logic cs_n,
  input wire logic serial_ctrl_in,
  output logic serial_result_out,
  output logic serial_result_oe_n,
  output logic busy_out,
  output logic busy_oe_n,
  // pen touch line, open drain
  output logic touch_detect_irq_n_out,
  output logic touch_detect_irq_n_oe_n,
  // converter side, system clock
  input wire logic pen_touch,
  input wire logic [RES_BITS-1:0] sample_x_pos,
  input wire logic [RES_BITS-1:0] sample_y_pos,
  input wire logic [RES_BITS-1:0] aux_input_one,
  input wire logic [RES_BITS-1:0] aux_input_two,
  output var tasp_pkg::tasp_chan_t channel_sel,
  output logic sample_strobe,
  output logic low_res_mode,
  output logic pen_irq_off
);

  // elaboration check: the edge counts below assume the twelve-bit word
  if (RES_BITS != `TASP_RES_BITS) begin : g_bad_res_bits
    $error("tasp_serial_port: RES_BITS must be twelve");
  end

  // ---------------- link domain ----------------
  // the whole link side is cleared while select is high; the clock
  // may stop between frames so nothing relies on idle edges
  logic link_clr; // async clear of the link logic
  logic started; // start bit seen
  logic [3:0] rise_cnt; // control bits taken so far
  logic [`TASP_CTRL_BITS-1:0] ctrl; // control byte, start bit first
  logic ctrl_done; // level: control byte complete
  logic [4:0] fall_cnt; // falling edges since start bit
  logic acq_req; // level handshake request to system side
  logic ack_meta; // ack synchroniser stage one
  logic ack_sync; // ack synchroniser stage two
  logic [RES_BITS-1:0] shift; // result shift register
  logic busy; // conversion in progress
  logic dout; // registered result bit
  logic [2:0] req_addr; // address bits held for the system side
  logic req_mode; // resolution bit held for the system side

  // ---------------- crossing signals ----------------
  // written on clk, read on the link side only through the ack
  // synchroniser or once that ack has been seen
  logic sys_ack; // ack level back to link side
  logic [RES_BITS-1:0] held; // sample held stable for the link

  assign link_clr = cs_n; // [RQ5]

  // tristate enables follow select directly
  assign serial_result_oe_n = cs_n; // [RQ2]
  assign busy_oe_n = cs_n; // [RQ3]
  assign serial_result_out = dout;
  assign busy_out = busy;

  // rising edges: wait for start bit, then take seven more bits
  always_ff @(posedge shift_and_convert_clock or posedge link_clr) begin
    if (link_clr) begin
      started <= 1'b0;
      rise_cnt <= 4'h0;
      ctrl <= `TASP_CTRL_RST;
      ctrl_done <= 1'b0;
    end else if (!started) begin
      // leading zeros before the start bit are ignored
      if (serial_ctrl_in) begin // [RQ4]
        started <= 1'b1;
        rise_cnt <= 4'h1;
        ctrl <= {{(`TASP_CTRL_BITS-1){1'b0}}, 1'b1};
      end
    end else if (rise_cnt < 4'(`TASP_CTRL_BITS)) begin
      ctrl <= {ctrl[`TASP_CTRL_BITS-2:0], serial_ctrl_in}; // [RQ4]
      rise_cnt <= rise_cnt + 4'h1;
      if (rise_cnt == 4'(`TASP_CTRL_BITS - 1)) begin
        ctrl_done <= 1'b1;
      end
    end
  end

  // falling-edge counter, saturates so trailing clocks give zeros
  always_ff @(negedge shift_and_convert_clock or posedge link_clr) begin
    if (link_clr) begin
      fall_cnt <= 5'h00;
    end else if (started && fall_cnt != `TASP_FALL_MAX) begin
      fall_cnt <= fall_cnt + 5'h01;
    end
  end

  // request the sample when acquisition opens
  always_ff @(negedge shift_and_convert_clock or posedge link_clr) begin
    if (link_clr) begin
      acq_req <= 1'b0;
    end else if (started && fall_cnt == `TASP_FALL_ACQ - 5'h01) begin
      acq_req <= 1'b1; // [RQ9]
    end
  end

  // address and mode latched as acquisition opens; the control byte
  // keeps shifting after this edge, so the system side reads it only for PD0, once complete
  always_ff @(negedge shift_and_convert_clock or posedge link_clr) begin
    if (link_clr) begin
      req_addr <= 3'h0;
      req_mode <= 1'b0;
    end else if (started && fall_cnt == `TASP_FALL_ACQ - 5'h01) begin
      // three control bits still to come, so the fields sit lower [RQ9]
      req_addr <= ctrl[`TASP_CTRL_A2-`TASP_ACQ_SHIFT:`TASP_CTRL_A0-`TASP_ACQ_SHIFT];
      req_mode <= ctrl[`TASP_CTRL_MODE-`TASP_ACQ_SHIFT];
    end
  end

  // ack back from system side, two flops on the link clock
  always_ff @(negedge shift_and_convert_clock or posedge link_clr) begin
    if (link_clr) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= sys_ack;
      ack_sync <= ack_meta;
    end
  end

  // result word loaded and shifted, all on falling edges of the serial clock
  always_ff @(negedge shift_and_convert_clock or posedge link_clr) begin
    if (link_clr) begin
      shift <= `TASP_RESULT_RST;
      dout <= 1'b0;
    end else if (started && fall_cnt == `TASP_FALL_BUSY - 5'h01) begin
      // three cycles of acquisition are over, conversion starts [RQ6] [RQ9]
      // a late ack reads as zero rather than a torn word
      if (!ack_sync) begin
        shift <= `TASP_RESULT_RST;
      end else if (req_mode) begin
        // low resolution keeps the top bits, zeros follow them
        shift <= {held[RES_BITS-1:RES_BITS-`TASP_RES_BITS_LOW],
                  {(RES_BITS-`TASP_RES_BITS_LOW){1'b0}}};
      end else begin
        shift <= held; // straight binary, no recoding [RQ11]
      end
    end else if (started && fall_cnt >= `TASP_FALL_MSB - 5'h01) begin
      // msb first, zeros fill behind the last bit [RQ1] [RQ10]
      dout <= shift[RES_BITS-1];
      shift <= {shift[RES_BITS-2:0], 1'b0};
    end
  end

  // busy stands from the load edge to the first result edge
  always_ff @(negedge shift_and_convert_clock or posedge link_clr) begin
    if (link_clr) begin
      busy <= 1'b0;
    end else if (started && fall_cnt == `TASP_FALL_BUSY - 5'h01) begin
      busy <= 1'b1; // [RQ6]
    end else if (started && fall_cnt >= `TASP_FALL_MSB - 5'h01) begin
      busy <= 1'b0;
    end
  end

  // ---------------- system domain ----------------
  // everything below runs on clk and sees the link only through
  // two-flop synchronisers, fields held under the request, or ctrl once done_sync rises
  logic req_meta; // request synchroniser stage one
  logic req_sync; // request synchroniser stage two
  logic done_meta; // control-done synchroniser stage one
  logic done_sync; // control-done synchroniser stage two
  logic done_prev; // for edge detection on done_sync
  logic pen_meta; // pen input synchroniser stage one
  logic pen_sync; // pen input synchroniser stage two
  logic take_sample; // fresh request not yet answered
  tasp_pkg::tasp_chan_t next_chan; // decoded channel

  // request synchroniser, a level that stays up for the rest of the frame
  always_ff @(posedge clk) begin
    if (rst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      req_meta <= acq_req;
      req_sync <= req_meta;
    end
  end

  // control-done synchroniser; done_prev starts low like the idle
  // level, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      done_meta <= ctrl_done;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  // pen input synchroniser, the pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (rst) begin
      pen_meta <= 1'b0;
      pen_sync <= 1'b0;
    end else begin
      pen_meta <= pen_touch;
      pen_sync <= pen_meta;
    end
  end

  // address bits map to channel numbers one to four; req_addr only
  // moves while no request is up, so it is stable whenever it is used
  always_comb begin
    unique case (req_addr)
      `TASP_ADDR_X_POS: next_chan = tasp_pkg::TASP_CH_X_POS; // [RQ8]
      `TASP_ADDR_Y_POS: next_chan = tasp_pkg::TASP_CH_Y_POS; // [RQ8]
      `TASP_ADDR_AUX_ONE: next_chan = tasp_pkg::TASP_CH_AUX_ONE; // [RQ8]
      `TASP_ADDR_AUX_TWO: next_chan = tasp_pkg::TASP_CH_AUX_TWO; // [RQ8]
      default: next_chan = tasp_pkg::TASP_CH_NONE;
    endcase
  end

  // one sample per rising request level
  assign take_sample = req_sync && !sys_ack;

  // four-phase ack: raised on a new request, dropped once it falls
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_ack <= 1'b0;
    end else if (take_sample) begin
      sys_ack <= 1'b1;
    end else if (!req_sync) begin
      sys_ack <= 1'b0;
    end
  end

  // single-cycle strobe toward the converter as the sample is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= take_sample; // [RQ9]
    end
  end

  // channel and resolution of the last sample, kept until the next one
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_sel <= tasp_pkg::TASP_CH_NONE;
      low_res_mode <= 1'b0;
    end else if (take_sample) begin
      channel_sel <= next_chan; // [RQ8]
      low_res_mode <= req_mode;
    end
  end

  // sampled word, stable for the link until the next request
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= `TASP_RESULT_RST;
    end else if (take_sample) begin
      // unmapped addresses convert as zero
      unique case (next_chan)
        tasp_pkg::TASP_CH_X_POS: held <= sample_x_pos;
        tasp_pkg::TASP_CH_Y_POS: held <= sample_y_pos;
        tasp_pkg::TASP_CH_AUX_ONE: held <= aux_input_one;
        tasp_pkg::TASP_CH_AUX_TWO: held <= aux_input_two;
        default: held <= `TASP_RESULT_RST;
      endcase
    end
  end

  // pen interrupt enable survives across frames, taken per control byte;
  // ctrl stops shifting once complete, but a host that deselects within
  // a few clk periods of the last control bit loses the setting
  always_ff @(posedge clk) begin
    if (rst) begin
      pen_irq_off <= 1'b0;
    end else if (done_sync && !done_prev) begin
      pen_irq_off <= ctrl[`TASP_CTRL_PD0];
    end
  end

  // open drain: only ever drives low, released otherwise
  assign touch_detect_irq_n_out = 1'b0; // [RQ7]
  assign touch_detect_irq_n_oe_n = ~(pen_sync & ~pen_irq_off); // [RQ7]

endmodule
`default_nettype wire

/* tb/tasp_port_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module tasp_port_monitor (
  // clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_and_convert_clock,
  // link pins
  input wire logic cs_n,
  input wire logic serial_result_oe_n,
  input wire logic busy_out,
  input wire logic busy_oe_n,
  // pen line and converter side
  input wire logic touch_detect_irq_n_out,
  input wire logic touch_detect_irq_n_oe_n,
  input wire logic pen_touch,
  input wire logic sample_strobe,
  input wire logic pen_irq_off
);
  // enables are plain copies of select, so any edge of select shows at once
  a_dout_float_cs: assert property (@(posedge clk) disable iff (rst)
    serial_result_oe_n == cs_n) else $error("result enable differs from select");
  a_busy_float_cs: assert property (@(posedge clk) disable iff (rst)
    busy_oe_n == cs_n) else $error("busy enable differs from select");
  // busy may only stand one link period
  a_busy_one_period: assert property (@(negedge shift_and_convert_clock)
    disable iff (cs_n) busy_out |=> !busy_out) else $error("busy held too long");
  // open drain: never drives high
  a_irq_only_low: assert property (@(posedge clk) disable iff (rst)
    !touch_detect_irq_n_oe_n |-> !touch_detect_irq_n_out) else $error("pen line driven high");
  // five cycles covers the two sync flops; the enable after them is combinational
  a_pen_pulls_line: assert property (@(posedge clk) disable iff (rst)
    (pen_touch && !pen_irq_off) [*5] |-> !touch_detect_irq_n_oe_n) else $error("pen not shown");
  a_pen_releases: assert property (@(posedge clk) disable iff (rst)
    (!pen_touch || pen_irq_off) [*5] |-> touch_detect_irq_n_oe_n) else $error("pen line held");
  a_strobe_single: assert property (@(posedge clk) disable iff (rst)
    sample_strobe |=> !sample_strobe) else $error("sample strobe too long");
  a_strobe_selected: assert property (@(posedge clk) disable iff (rst)
    sample_strobe |-> !cs_n) else $error("sample taken while deselected");
  // main scenarios reached
  c_sample: cover property (@(posedge clk) sample_strobe);
  c_busy: cover property (@(posedge clk) busy_out && !busy_oe_n);
  c_pen: cover property (@(posedge clk) !touch_detect_irq_n_oe_n);
endmodule
bind tasp_serial_port tasp_port_monitor u_monitor (.clk(clk), .rst(rst),
  .shift_and_convert_clock(shift_and_convert_clock), .cs_n(cs_n),
  .serial_result_oe_n(serial_result_oe_n), .busy_out(busy_out), .busy_oe_n(busy_oe_n),
  .touch_detect_irq_n_out(touch_detect_irq_n_out),
  .touch_detect_irq_n_oe_n(touch_detect_irq_n_oe_n), .pen_touch(pen_touch),
  .sample_strobe(sample_strobe), .pen_irq_off(pen_irq_off));
`default_nettype wire

/* tb/tasp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tasp_host_model (
  // link to the device
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  // idle: clock still low, deselected; the link logic has no reset of
  // its own, so a first deselect edge clears it
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    din = 1'b0;
    #1 cs_n = 1'b1;
  end
  // one frame of ncyc link periods of 64 ns; result sampled on rises 10 onward
  task automatic xfer(input logic [7:0] ctrl, input int ncyc, output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0; // select before the first rise
    #43;
    for (int i = 1; i <= ncyc; i++) begin
      din = (i <= 8) ? ctrl[8-i] : ~din; // start first, then toggling filler
      #32 sclk = 1'b1; // rise takes control and, from rise 10, the result bit
      if (i >= 10) r = {r[14:0], dout};
      #32 sclk = 1'b0;
    end
    #40 cs_n = 1'b1; // held low until all bits read
    din = ~din; // released line shows no stale level
    #64; // a full link period deselected before any next frame
  endtask
endmodule
`default_nettype wire

/* tb/tasp_testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tasp_cfg.svh"
module testbench;
  // clock, reset and converter inputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pen_touch = 1'b0;
  logic [11:0] sample_x_pos = 12'h000, sample_y_pos = 12'h000;
  logic [11:0] aux_input_one = 12'h000, aux_input_two = 12'h000;
  // link and design outputs
  wire logic shift_and_convert_clock, cs_n, serial_ctrl_in, serial_result_out;
  wire logic serial_result_oe_n, busy_out, busy_oe_n, sample_strobe, low_res_mode;
  wire logic touch_detect_irq_n_out, touch_detect_irq_n_oe_n, pen_irq_off;
  tasp_pkg::tasp_chan_t channel_sel;
  int bad_count = 0, compares = 0, strobes = 0;
  logic [15:0] res;
  // last entry is an unmapped code
  logic [2:0] addr_tab [5] = '{`TASP_ADDR_X_POS, `TASP_ADDR_Y_POS, `TASP_ADDR_AUX_ONE,
    `TASP_ADDR_AUX_TWO, 3'h0};
  always #5 clk = ~clk;
  tasp_serial_port uut (.clk, .rst, .shift_and_convert_clock, .cs_n, .serial_ctrl_in,
    .serial_result_out, .serial_result_oe_n, .busy_out, .busy_oe_n, .touch_detect_irq_n_out,
    .touch_detect_irq_n_oe_n, .pen_touch, .sample_x_pos, .sample_y_pos, .aux_input_one,
    .aux_input_two, .channel_sel, .sample_strobe, .low_res_mode, .pen_irq_off);
  // a floating result line reads as the inverse of its last level
  tasp_host_model host (.sclk(shift_and_convert_clock), .cs_n, .din(serial_ctrl_in),
    .dout(serial_result_oe_n ? ~serial_result_out : serial_result_out));
  // count samples taken
  always @(posedge clk) if (sample_strobe === 1'b1) strobes++;
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one conversion frame against the reference model
  task automatic frame(input int k, input logic mode, input logic pd0);
    logic [11:0] v;
    int s0;
    v = (k == 0) ? sample_x_pos : (k == 1) ? sample_y_pos : (k == 2) ? aux_input_one :
      (k == 3) ? aux_input_two : 12'h000;
    s0 = strobes;
    host.xfer({1'b1, addr_tab[k], mode, 2'b00, pd0}, 25, res);
    chk("result", mode ? {v[11:4], 8'h00} : {v, 4'h0}, res);
    chk("channel", 16'(k < 4 ? k + 1 : 0), 16'(channel_sel));
    chk("strobes", 16'h0001, 16'(strobes - s0));
    chk("mode", {15'h0, mode}, {15'h0, low_res_mode});
    chk("irq off", {15'h0, pd0}, {15'h0, pen_irq_off});
    $display("frame test done channel %0d", k);
    @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h4fca));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // every channel code in both resolutions
    for (int m = 0; m < 2; m++) for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      sample_x_pos <= 12'($urandom);
      sample_y_pos <= 12'($urandom);
      aux_input_one <= 12'($urandom);
      aux_input_two <= 12'($urandom);
      @(posedge clk);
      frame(k, m[0], 1'b0);
    end
    // frame cut short, then a clean one
    host.xfer(8'hd0, 12, res);
    chk("oe after abort", 16'h0001, {15'h0, serial_result_oe_n});
    frame(0, 1'b0, 1'b0);
    // pen line with interrupt on, then off
    for (int p = 0; p < 2; p++) begin
      frame(1, 1'b0, p[0]);
      pen_touch <= 1'b1;
      repeat (8) @(posedge clk);
      chk("irq drive", {15'h0, p[0]}, {15'h0, touch_detect_irq_n_oe_n});
      pen_touch <= 1'b0;
      repeat (8) @(posedge clk);
      chk("irq release", 16'h0001, {15'h0, touch_detect_irq_n_oe_n});
      $display("pen test done");
    end
    report_and_stop;
  end
  // about two and a half times the expected run
  initial begin
    #60000;
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
